//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tb_top;
  import tmr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mrst_n = 1'b1;
  logic stby = 1'b0;
  logic rtc = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic pin_run = 1'b0;
  logic dma_slow = 1'b1;
  logic req_q = 1'b0;
  logic pin_lvl, pin_wire, dma_done, timer_clock_pin_out, timer_clock_pin_oe, pready, pslverr, cap_irq, dma_req, err;
  logic [31:0] prdata, rd, v;
  logic [31:0] snap [4];
  logic [31:0] shadow [int];
  tmr_ch_t unf_irq;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int req_seen = 0;
  int req_exp = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and the pin level resolved from both drivers.
  always #10 clk = ~clk;
  assign pin_wire = timer_clock_pin_oe ? timer_clock_pin_out : pin_lvl;

  tmr_top u_tmr_top (
    .CLK_IN(clk), .RST_N_IN(rst_n), .MRST_N_IN(mrst_n), .STANDBY_IN(stby),
    .RTC_CLK_IN(rtc), .TIMER_CLOCK_PIN_IN(pin_wire), .TIMER_CLOCK_PIN_OUT(timer_clock_pin_out), .TIMER_CLOCK_PIN_OE_OUT(timer_clock_pin_oe),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .UNF_IRQ_OUT(unf_irq), .CAP_IRQ_OUT(cap_irq), .DMA_REQ_OUT(dma_req),
    .DMA_DONE_IN(dma_done)
  );

  tmr_far_model u_tmr_far_model (
    .clk_in(clk), .pin_run_in(pin_run), .dma_slow_in(dma_slow), .dma_req_in(dma_req),
    .pin_out(pin_lvl), .dma_done_out(dma_done)
  );

  // Cycle count with timeout, a slow RTC clock, and counting of DMA requests.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles % 8 == 7) rtc <= ~rtc;
    req_q <= dma_req;
    if (dma_req === 1'b1 && req_q === 1'b0) req_seen <= req_seen + 1;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // One APB transfer, held until ready is seen, then one idle edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    @(posedge clk);
  endtask : apb

  function automatic logic [7:0] chad(input int c, input int s);
    return 8'(16 * c + 16 + 4 * s);
  endfunction : chad

  // Bits that hold what was written; status flags are expected clear.
  function automatic logic [31:0] wmask(input logic [7:0] a);
    if (a == `TMR_OFF_PINCTL) return 32'h00000001;
    if (a == `TMR_OFF_RUNLO) return 32'h00000007;
    if (a == `TMR_OFF_RUNHI) return 32'h00000003;
    if (a[3:0] != 4'h8) return 32'hFFFFFFFF;
    if (a[7:4] == 4'h3) return 32'h000000FF;
    return (a[7:4] > 4'h3) ? 32'h00000027 : 32'h0000003F;
  endfunction : wmask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    shadow[a] = d & wmask(a);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask : rdc

  task automatic set_rst(input int last);
    shadow[`TMR_OFF_PINCTL] = 32'h00000000;
    shadow[`TMR_OFF_RUNLO] = 32'h00000000;
    if (last == 4) shadow[`TMR_OFF_RUNHI] = 32'h00000000;
    for (int c = 0; c <= last; c++) begin
      shadow[chad(c, 0)] = 32'hFFFFFFFF;
      shadow[chad(c, 1)] = 32'hFFFFFFFF;
      shadow[chad(c, 2)] = 32'h00000000;
    end
  endtask : set_rst

  task automatic check_regs(input int ncnt);
    rdc("pin_ctl", `TMR_OFF_PINCTL, shadow[`TMR_OFF_PINCTL]);
    rdc("run_lo", `TMR_OFF_RUNLO, shadow[`TMR_OFF_RUNLO]);
    rdc("run_hi", `TMR_OFF_RUNHI, shadow[`TMR_OFF_RUNHI]);
    for (int c = 0; c < 5; c++) begin
      rdc("reload", chad(c, 0), shadow[chad(c, 0)]);
      rdc("control", chad(c, 2), shadow[chad(c, 2)]);
      if (c < ncnt) rdc("counter", chad(c, 1), shadow[chad(c, 1)]);
    end
  endtask : check_regs

  task automatic wait_unf(input int ch, output int t);
    t = -1;
    for (int n = 0; n < 4500 && t < 0; n++) begin
      @(posedge clk);
      if (unf_irq[ch] === 1'b1) t = cycles;
    end
  endtask : wait_unf

  // Time two underflows of a reload of 3; zero period means no count at all.
  task automatic measure(input int ch, input logic [15:0] ctl, input int per);
    int t1;
    int t2;
    wr(chad(ch, 0), 32'h00000003);
    wr(chad(ch, 1), 32'h00000000);
    wr(chad(ch, 2), {16'h0000, ctl});
    wr(ch < 3 ? `TMR_OFF_RUNLO : `TMR_OFF_RUNHI, 32'h1 << (ch % 3));
    wait_unf(ch, t1);
    if (per == 0) chk("no_count", 32'hFFFFFFFF, 32'(t1));
    else begin
      wr(chad(ch, 2), {16'h0000, ctl});
      wait_unf(ch, t2);
      chk("period", 32'(per), 32'(t2 - t1));
    end
    wr(ch < 3 ? `TMR_OFF_RUNLO : `TMR_OFF_RUNHI, 32'h00000000);
    wr(chad(ch, 2), {16'h0000, ctl});
  endtask : measure

  task automatic burst(input int n);
    pin_run <= 1'b1;
    repeat (n) @(posedge clk);
    pin_run <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : burst

  task automatic wait_dma();
    for (int n = 0; n < 100 && dma_req !== 1'b0; n++) @(posedge clk);
    @(posedge clk);
    chk("dma_drop", 32'h0, {31'h0, dma_req});
  endtask : wait_dma

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(77));
    set_rst(4);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_regs(5);
    wr(`TMR_OFF_RUNLO, 32'hFFFFFFFF);
    wr(`TMR_OFF_RUNHI, 32'hFFFFFFFF);
    wr(`TMR_OFF_PINCTL, 32'hFFFFFFFF);
    for (int c = 0; c < 5; c++) begin
      wr(chad(c, 0), $urandom());
      wr(chad(c, 2), $urandom());
    end
    check_regs(0);
    wr(`TMR_OFF_RUNLO, 32'h00000000);
    wr(`TMR_OFF_RUNHI, 32'h00000000);
    // Random capture control must be off before the pin turns to input and starts toggling.
    wr(chad(2, 2), 32'h00000000);
    wr(`TMR_OFF_PINCTL, 32'h00000000);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("err_unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `TMR_OFF_CAPT, 32'h00000000);
    chk("err_capt_write", 32'h1, {31'h0, err});
    pin_run <= 1'b1;
    measure(0, 16'h0020, 16);
    measure(1, 16'h0021, 64);
    measure(2, 16'h0022, 256);
    measure(3, 16'h0023, 1024);
    measure(4, 16'h0024, 4096);
    measure(1, 16'h0026, 64);
    measure(0, 16'h0027, 32);
    measure(1, 16'h002F, 32);
    measure(2, 16'h0037, 16);
    measure(3, 16'h0027, 0);
    // Capture: several edges under one pending request, then one while flagged.
    pin_run <= 1'b0;
    v = $urandom();
    wr(chad(2, 1), v);
    wr(chad(2, 2), 32'h000000C0);
    burst(24);
    req_exp++;
    chk("dma_reqs", 32'(req_exp), 32'(req_seen));
    chk("cap_irq", 32'h1, {31'h0, cap_irq});
    rdc("capture", `TMR_OFF_CAPT, v);
    rdc("control2", chad(2, 2), 32'h000002C0);
    wait_dma();
    wr(chad(2, 1), ~v);
    burst(8);
    req_exp++;
    chk("dma_reqs", 32'(req_exp), 32'(req_seen));
    rdc("capture", `TMR_OFF_CAPT, v);
    wait_dma();
    wr(chad(2, 2), 32'h000000C0);
    @(posedge clk);
    chk("cap_irq", 32'h0, {31'h0, cap_irq});
    wr(chad(2, 2), 32'h00000080);
    dma_slow <= 1'b0;
    burst(8);
    req_exp++;
    chk("dma_reqs", 32'(req_exp), 32'(req_seen));
    chk("cap_irq", 32'h0, {31'h0, cap_irq});
    rdc("control2", chad(2, 2), 32'h00000280);
    wait_dma();
    wr(chad(2, 2), 32'h00000000);
    burst(8);
    chk("dma_reqs", 32'(req_exp), 32'(req_seen));
    rdc("control2", chad(2, 2), 32'h00000000);
    // Standby: the RTC channel and channel 3 keep their run bits; only the RTC channel keeps counting.
    wr(chad(0, 2), 32'h00000006);
    wr(chad(1, 2), 32'h00000000);
    wr(chad(3, 2), 32'h00000000);
    for (int c = 0; c < 4; c++) wr(chad(c, 1), 32'h00001000);
    wr(`TMR_OFF_RUNLO, 32'h00000003);
    wr(`TMR_OFF_RUNHI, 32'h00000001);
    stby <= 1'b1;
    repeat (6) @(posedge clk);
    rdc("run_lo", `TMR_OFF_RUNLO, 32'h00000001);
    rdc("run_hi", `TMR_OFF_RUNHI, 32'h00000001);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, chad(c, 1), 32'h00000000);
      snap[c] = rd;
    end
    repeat (40) @(posedge clk);
    rdc("cnt1_hold", chad(1, 1), snap[1]);
    rdc("cnt3_hold", chad(3, 1), snap[3]);
    apb(1'b0, chad(0, 1), 32'h00000000);
    chk("rtc_count", 32'h1, {31'h0, rd < snap[0]});
    stby <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, chad(3, 1), 32'h00000000);
    chk("cnt3_resume", 32'h1, {31'h0, rd < snap[3]});
    // Manual reset spares channels 3 and 4 and the second run register.
    wr(`TMR_OFF_PINCTL, 32'h00000001);
    repeat (3) @(posedge clk);
    chk("pin_oe", 32'h1, {31'h0, timer_clock_pin_oe});
    // The driven pin follows the RTC clock, which flips exactly once every 8 cycles.
    v = {31'h0, timer_clock_pin_out};
    repeat (8) @(posedge clk);
    chk("pin_drive", {31'h0, ~v[0]}, {31'h0, timer_clock_pin_out});
    wr(chad(3, 0), 32'h00000077);
    wr(chad(3, 2), 32'h00000021);
    wr(chad(0, 0), 32'h00000055);
    mrst_n <= 1'b0;
    repeat (6) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    set_rst(2);
    check_regs(3);
    conclude();
  end
endmodule : tb_top

//--- verif/tmr_far_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of the timer: the clock pin source and a DMA controller.
module tmr_far_model (
  input wire logic clk_in,
  input wire logic pin_run_in,
  input wire logic dma_slow_in,
  input wire logic dma_req_in,
  output logic pin_out,
  output logic dma_done_out
);
  logic [1:0] ph_r;
  logic [7:0] wait_r;

  // Start idle with the pin low.
  initial begin
    ph_r = 2'h0;
    wait_r = 8'h00;
    pin_out = 1'b0;
    dma_done_out = 1'b0;
  end

  // The pin toggles every fourth cycle, so it never beats an eighth of the clock.
  always @(posedge clk_in) begin
    if (pin_run_in) begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        pin_out <= ~pin_out;
      end
    end
  end

  // One done pulse per request, soon or late, then wait for the request to drop.
  always @(posedge clk_in) begin
    wait_r <= dma_req_in ? wait_r + 8'h01 : 8'h00;
    dma_done_out <= dma_req_in && (wait_r == (dma_slow_in ? 8'h28 : 8'h02));
  end
endmodule : tmr_far_model

//--- verilog/tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Register byte addresses on the APB slave.
`define TMR_OFF_PINCTL 8'h00
`define TMR_OFF_RUNLO 8'h04
`define TMR_OFF_RUNHI 8'h08
`define TMR_OFF_CAPT 8'h60
// Channel n occupies the 16-byte slot starting at (n + 1) * 16.
`define TMR_CH_SLOT0 3'h1
`define TMR_CH_SLOTN 3'h5
`define TMR_SLOT_RELOAD 2'h0
`define TMR_SLOT_COUNT 2'h1
`define TMR_SLOT_CTL 2'h2

// Reset values.
`define TMR_RST_BYTE 8'h00
`define TMR_RST_CNT 32'hFFFFFFFF
`define TMR_RST_CTL 16'h0000

// Writable bits of each control register (flags included for clearing).
`define TMR_MASK_CH01 16'h013F
`define TMR_MASK_CH2 16'h03FF
`define TMR_MASK_CH34 16'h0127

// Prescaler tick masks: the tick fires when the masked bits are all ones.
`define TMR_DIV4_MASK 10'h003
`define TMR_DIV16_MASK 10'h00F
`define TMR_DIV64_MASK 10'h03F
`define TMR_DIV256_MASK 10'h0FF
`define TMR_DIV1024_MASK 10'h3FF

`endif

//--- verilog/tmr_pkg.sv
package tmr_pkg;

  // Count source codes held in the low three control bits.
  typedef enum logic [2:0] {
    TMR_SRC_DIV4 = 3'b000,
    TMR_SRC_DIV16 = 3'b001,
    TMR_SRC_DIV64 = 3'b010,
    TMR_SRC_DIV256 = 3'b011,
    TMR_SRC_DIV1024 = 3'b100,
    TMR_SRC_NONE = 3'b101,
    TMR_SRC_RTC = 3'b110,
    TMR_SRC_PIN = 3'b111
  } tmr_src_e;

  // Layout of one channel control register.
  typedef struct packed {
    logic [5:0] rsvd;
    logic cap_flag;
    logic unf_flag;
    logic [1:0] cap_ctl;
    logic unf_ie;
    logic [1:0] edge_sel;
    tmr_src_e presc;
  } tmr_ctl_s;

  // One bit per channel.
  typedef logic [4:0] tmr_ch_t;

endpackage : tmr_pkg

//--- verilog/tmr_top.sv
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_top (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic MRST_N_IN,
  input wire logic STANDBY_IN,
  input wire logic RTC_CLK_IN,
  input wire logic TIMER_CLOCK_PIN_IN,
  output logic TIMER_CLOCK_PIN_OUT,
  output logic TIMER_CLOCK_PIN_OE_OUT,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output tmr_pkg::tmr_ch_t UNF_IRQ_OUT,
  output logic CAP_IRQ_OUT,
  output logic DMA_REQ_OUT,
  input wire logic DMA_DONE_IN
);
  import tmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Writable bit mask of a channel control register.
  function automatic logic [15:0] ctl_mask(input int ch);
    if (ch < 2) begin
      return `TMR_MASK_CH01;
    end
    if (ch == 2) begin
      return `TMR_MASK_CH2;
    end
    return `TMR_MASK_CH34;
  endfunction : ctl_mask

  // Tick of one internal prescaler division.
  function automatic logic div_tick(input tmr_src_e code, input logic [9:0] div);
    logic [9:0] m;
    m = 10'h000;
    case (code)
      TMR_SRC_DIV4: m = `TMR_DIV4_MASK;
      TMR_SRC_DIV16: m = `TMR_DIV16_MASK;
      TMR_SRC_DIV64: m = `TMR_DIV64_MASK;
      TMR_SRC_DIV256: m = `TMR_DIV256_MASK;
      TMR_SRC_DIV1024: m = `TMR_DIV1024_MASK;
      default: m = 10'h000;
    endcase
    return (code <= TMR_SRC_DIV1024) && ((div & m) == m);
  endfunction : div_tick

  // Pin edge selection: 00 rising, 01 falling, 1x both.
  function automatic logic edge_hit(input logic [1:0] es, input logic rise, input logic fall);
    return es[1] ? (rise | fall) : (es[0] ? fall : rise);
  endfunction : edge_hit

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the pin, RTC clock, standby and manual reset.

  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [1:0] prev_r;
  wire pin_s = sync2_r[0];
  wire rtc_s = sync2_r[1];
  wire standby = sync2_r[2];
  wire mrst = ~sync2_r[3];

  // Two flip-flops per asynchronous level, then a stage for edge detection.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_r <= 4'h8;
      sync2_r <= 4'h8;
      prev_r <= 2'h0;
    end else begin
      sync1_r <= {MRST_N_IN, STANDBY_IN, RTC_CLK_IN, TIMER_CLOCK_PIN_IN};
      sync2_r <= sync1_r;
      prev_r <= sync2_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and count sources.

  logic pin_dir_r;
  logic [2:0] run_lo_r;
  logic [1:0] run_hi_r;
  logic [31:0] reload_r [5];
  logic [31:0] cnt_r [5];
  tmr_ctl_s ctl_r [5];
  logic [31:0] capt_r;
  logic [9:0] div_r;
  logic dma_r;
  logic pready_r;

  wire pin_in_mode = ~pin_dir_r;
  wire pin_rise = pin_in_mode & pin_s & ~prev_r[0];
  wire pin_fall = pin_in_mode & ~pin_s & prev_r[0];
  wire rtc_rise = rtc_s & ~prev_r[1];

  // Count tick of one channel; pin and divisions stop while the clock is off.
  // Every source is an argument so that the continuous assignment re-evaluates on each change.
  function automatic logic ch_tick(input int ch, input tmr_ctl_s c, input logic sb,
                                   input logic [9:0] dv, input logic rr, input logic pr,
                                   input logic pf);
    if (c.presc <= TMR_SRC_DIV1024) begin
      return ~sb & div_tick(c.presc, dv);
    end
    if (ch < 3 && c.presc == TMR_SRC_RTC) begin
      return rr;
    end
    if (ch < 3 && c.presc == TMR_SRC_PIN) begin
      return ~sb & edge_hit(c.edge_sel, pr, pf);
    end
    return 1'b0;
  endfunction : ch_tick

  // Free-running prescaler that halts with the module clock.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_r <= 10'h000;
    end else if (!standby) begin
      div_r <= div_r + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  wire [2:0] slot = PADDR_IN[6:4];
  wire in_slots = ~PADDR_IN[7] && slot >= `TMR_CH_SLOT0 && slot <= `TMR_CH_SLOTN;
  wire [2:0] ch_idx = slot - `TMR_CH_SLOT0;
  wire [1:0] sub = PADDR_IN[3:2];
  wire is_pinctl = PADDR_IN == `TMR_OFF_PINCTL;
  wire is_runlo = PADDR_IN == `TMR_OFF_RUNLO;
  wire is_runhi = PADDR_IN == `TMR_OFF_RUNHI;
  wire is_capt = PADDR_IN == `TMR_OFF_CAPT;
  wire is_chreg = in_slots && PADDR_IN[1:0] == 2'h0 && sub != 2'h3;
  wire mapped = is_pinctl | is_runlo | is_runhi | is_capt | is_chreg;
  wire bad = ~mapped | (is_capt & PWRITE_IN);
  wire acc_first = PSEL_IN & PENABLE_IN & ~pready_r;
  wire wr_ok = PSEL_IN & PENABLE_IN & pready_r & PWRITE_IN & ~bad;
  wire wr_pin = wr_ok & is_pinctl;
  wire wr_runlo = wr_ok & is_runlo;
  wire wr_runhi = wr_ok & is_runhi;

  // Per-channel write strobes, counter steps and events.
  tmr_ch_t wr_rel;
  tmr_ch_t wr_cnt;
  tmr_ch_t wr_ctl;
  tmr_ch_t run;
  tmr_ch_t dec;
  tmr_ch_t unf_ev;
  for (genvar g = 0; g < 5; g++) begin : g_ch
    wire sel = wr_ok & is_chreg & ch_idx == 3'(g);
    assign wr_rel[g] = sel & sub == `TMR_SLOT_RELOAD;
    assign wr_cnt[g] = sel & sub == `TMR_SLOT_COUNT;
    assign wr_ctl[g] = sel & sub == `TMR_SLOT_CTL;
    assign run[g] = (g < 3) ? run_lo_r[g % 3] : run_hi_r[g % 2 == 1 ? 0 : 1];
    assign dec[g] = run[g] & ch_tick(g, ctl_r[g], standby, div_r, rtc_rise, pin_rise, pin_fall);
    assign unf_ev[g] = dec[g] & cnt_r[g] == 32'h0 & ~wr_cnt[g];
  end

  // Capture on the chosen single edge of the pin, never in standby.
  wire cap_on = ctl_r[2].cap_ctl[1];
  wire cap_edge = ctl_r[2].edge_sel[0] ? pin_fall : pin_rise;
  wire cap_ev = cap_on & ~standby & cap_edge;

  // Next control value: masked write, flags cleared by 0, set wins.
  function automatic tmr_ctl_s ctl_next(input int ch, input tmr_ctl_s old, input logic wr,
                                        input logic unf, input logic cap);
    logic [15:0] m;
    tmr_ctl_s n;
    m = ctl_mask(ch);
    n = wr ? tmr_ctl_s'(PWDATA_IN[15:0] & m) : old;
    n.unf_flag = (old.unf_flag & (~wr | PWDATA_IN[8])) | unf;
    n.cap_flag = m[9] & ((old.cap_flag & (~wr | PWDATA_IN[9])) | cap);
    return n;
  endfunction : ctl_next

  // Read selection.
  wire [31:0] ch_rd = sub == `TMR_SLOT_RELOAD ? reload_r[ch_idx] :
                      sub == `TMR_SLOT_COUNT ? cnt_r[ch_idx] : {16'h0000, ctl_r[ch_idx]};
  wire [31:0] rd_data = is_pinctl ? {31'h0, pin_dir_r} :
                        is_runlo ? {29'h0, run_lo_r} :
                        is_runhi ? {30'h0, run_hi_r} :
                        is_capt ? capt_r :
                        is_chreg ? ch_rd : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, read data sampled on the first access cycle.

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_r <= 1'b0;
      PRDATA_OUT <= 32'h0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      pready_r <= acc_first;
      PSLVERR_OUT <= acc_first & bad;
      if (acc_first) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h0 : rd_data;
      end
    end
  end
  assign PREADY_OUT = pready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin control and run registers.

  // Low run bits of non-RTC channels drop while in standby.
  wire [2:0] rtc_keep = {ctl_r[2].presc == TMR_SRC_RTC, ctl_r[1].presc == TMR_SRC_RTC,
                         ctl_r[0].presc == TMR_SRC_RTC};
  wire [2:0] run_lo_nxt = (wr_runlo ? PWDATA_IN[2:0] : run_lo_r) & (standby ? rtc_keep : 3'h7);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_dir_r <= `TMR_RST_BYTE == 8'h00 ? 1'b0 : 1'b1;
      run_lo_r <= 3'h0;
      run_hi_r <= 2'h0;
    end else begin
      if (mrst) begin
        pin_dir_r <= 1'b0;
        run_lo_r <= 3'h0;
      end else begin
        pin_dir_r <= wr_pin ? PWDATA_IN[0] : pin_dir_r;
        run_lo_r <= run_lo_nxt;
      end
      if (wr_runhi) begin
        run_hi_r <= PWDATA_IN[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel counters, constants and control; channels 3-4 ignore manual reset.

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < 5; i++) begin
        reload_r[i] <= `TMR_RST_CNT;
        cnt_r[i] <= `TMR_RST_CNT;
        ctl_r[i] <= `TMR_RST_CTL;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (mrst && i < 3) begin
          reload_r[i] <= `TMR_RST_CNT;
          cnt_r[i] <= `TMR_RST_CNT;
          ctl_r[i] <= `TMR_RST_CTL;
        end else begin
          if (wr_rel[i]) begin
            reload_r[i] <= PWDATA_IN;
          end
          if (wr_cnt[i]) begin
            cnt_r[i] <= PWDATA_IN;
          end else if (dec[i]) begin
            cnt_r[i] <= unf_ev[i] ? reload_r[i] : cnt_r[i] - 32'h1;
          end
          ctl_r[i] <= ctl_next(i, ctl_r[i], wr_ctl[i], unf_ev[i], i == 2 && cap_ev);
        end
      end
    end
  end

  // Capture register holds its value across every reset.
  always_ff @(posedge CLK_IN) begin
    if (cap_ev && !ctl_r[2].cap_flag) begin
      capt_r <= cnt_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests and pin drive.

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dma_r <= 1'b0;
      UNF_IRQ_OUT <= 5'h00;
      CAP_IRQ_OUT <= 1'b0;
      TIMER_CLOCK_PIN_OUT <= 1'b0;
      TIMER_CLOCK_PIN_OE_OUT <= 1'b0;
    end else begin
      if (cap_ev && !dma_r) begin
        dma_r <= 1'b1;
      end else if (DMA_DONE_IN) begin
        dma_r <= 1'b0;
      end
      for (int i = 0; i < 5; i++) begin
        UNF_IRQ_OUT[i] <= ctl_r[i].unf_flag & ctl_r[i].unf_ie;
      end
      CAP_IRQ_OUT <= ctl_r[2].cap_flag & ctl_r[2].cap_ctl == 2'b11;
      TIMER_CLOCK_PIN_OUT <= rtc_s;
      TIMER_CLOCK_PIN_OE_OUT <= pin_dir_r;
    end
  end
  assign DMA_REQ_OUT = dma_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN || mrst);

  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence

  property p_apb_ready;
    s_setup ##1 s_access |=> PREADY_OUT;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB answer late");

  property p_reload;
    unf_ev[0] |=> cnt_r[0] == $past(reload_r[0]) && ctl_r[0].unf_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("Reload failed");

  property p_dec;
    dec[1] && !wr_cnt[1] && cnt_r[1] != 32'h0 |=> cnt_r[1] == $past(cnt_r[1]) - 32'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("Decrement wrong");

  property p_standby_hold;
    standby && !wr_cnt[3] |=> $stable(cnt_r[3]);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("Count in standby");

  property p_unf_irq;
    ctl_r[4].unf_flag && ctl_r[4].unf_ie |=> UNF_IRQ_OUT[4];
  endproperty
  a_unf_irq: assert property (p_unf_irq) else $error("Underflow irq missing");

  property p_cap_keep;
    cap_ev && ctl_r[2].cap_flag |=> $stable(capt_r);
  endproperty
  a_cap_keep: assert property (p_cap_keep) else $error("Capture overwritten");

  property p_dma_hold;
    DMA_REQ_OUT && !DMA_DONE_IN |=> DMA_REQ_OUT;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("DMA request dropped");

  property p_cap_irq;
    ##1 CAP_IRQ_OUT == ($past(ctl_r[2].cap_flag) && $past(ctl_r[2].cap_ctl) == 2'b11);
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("Capture irq wrong");

  property p_mrst;
    disable iff (!RST_N_IN) mrst |=> run_lo_r == 3'h0 && !pin_dir_r;
  endproperty
  a_mrst: assert property (p_mrst) else $error("Manual reset missed");

endmodule : tmr_top
